// file: bench/adks_host.sv
`timescale 1ns/100ps
`default_nettype none
module adks_host (
  // clock and read data
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  // register strobes
  output logic o_wr, o_rd,
  output logic [7:0] o_addr, o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h00000;
  // one byte per call; on release the strobes drop and address and data are inverted so stale values never look valid
  task automatic xfer(input logic rd, input logic [7:0] a, d, output logic [7:0] q);
    @(negedge i_mclk);
    {o_rd, o_wr, o_addr, o_wdata} = {rd, !rd, a, d};
    @(negedge i_mclk);
    q = i_rdata;
    {o_rd, o_wr, o_addr, o_wdata} = {2'h0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// file: bench/adks_settings_props.sv
`timescale 1ns/100ps
`default_nettype none
module adks_settings_props (
  // watched ports
  input wire logic i_mclk, i_rst, i_wr, i_removal, i_adc_done, i_insertion_sense_pin,
  input wire logic [7:0] i_addr, i_wdata, i_int_status,
  input wire logic o_sw_reset, o_det_start, o_adc_start, o_adc_int_set, o_manual_sw, o_key_detect_run, o_raw_key_mode
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // write decode per register
  wire w4 = i_wr && i_addr == 8'h04;
  wire w5 = i_wr && i_addr == 8'h05;
  // levels lag the register by a cycle
  sequence keys_off;
    ##[1:2] (!o_key_detect_run && !o_raw_key_mode);
  endsequence
  sw_reset_a: assert property (w4 && i_wdata[7] |=> o_sw_reset) else $error("soft reset pulse missing");
  manual_sw_a: assert property (w4 && !i_wdata[7] |-> ##2 o_manual_sw == $past(i_wdata[6], 2))
    else $error("override level wrong");
  det_refuse_a: assert property (w4 && i_wdata[4] && (i_int_status != 8'h00 || i_insertion_sense_pin)
    |=> !o_det_start) else $error("detection started while refused");
  adc_start_a: assert property (w5 && i_wdata[2:0] == 3'h7 |=> o_adc_start) else $error("adc start missing");
  adc_refuse_a: assert property (w5 && i_wdata[0] && !(i_wdata[2] && i_wdata[1]) |=> !o_adc_start)
    else $error("adc started while refused");
  raw_clear_a: assert property (w5 && !i_wdata[2] |-> keys_off) else $error("raw mode kept");
  removal_a: assert property (i_removal |-> keys_off) else $error("key enable kept on removal");
  adc_int_a: assert property (o_adc_int_set |-> $past(i_adc_done)) else $error("adc interrupt without done");
endmodule
bind adks_settings adks_settings_props u_adks_settings_props (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr(i_wr),
  .i_removal(i_removal), .i_adc_done(i_adc_done), .i_insertion_sense_pin(i_insertion_sense_pin),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_int_status(i_int_status), .o_sw_reset(o_sw_reset),
  .o_det_start(o_det_start), .o_adc_start(o_adc_start), .o_adc_int_set(o_adc_int_set),
  .o_manual_sw(o_manual_sw), .o_key_detect_run(o_key_detect_run), .o_raw_key_mode(o_raw_key_mode));
`default_nettype wire

// file: bench/adks_settings_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adks_settings_tb;
  logic i_mclk = 1'h0, i_rst = 1'h1, rem = 1'h0, det_done = 1'h0, adc_done = 1'h0, sense = 1'h1;
  logic wr, rd, det_start, adc_start, adc_int, sw_reset, debounced, fet_on, key_run, raw_mode;
  logic key_rd = 1'h0, matrix = 1'h1;
  logic [1:0] key_bits, key_ev = 2'h0;
  logic [7:0] status = 8'h00, addr, wdata, rdata, q;
  int num_errors = 0, comparisons = 0;
  always #5 i_mclk = ~i_mclk;
  adks_settings #(.DEB_SCALE(1)) u_adks_settings (.i_mclk(i_mclk), .i_rst(i_rst), .i_wr(wr), .i_rd(rd),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_insertion_sense_pin(sense), .i_removal(rem),
    .i_int_status(status), .i_det_done(det_done), .i_adc_done(adc_done), .i_key_switch_matrix_valid(matrix),
    .i_key_int_read(key_rd), .i_key_event(key_ev), .o_sw_reset(sw_reset), .o_manual_sw(), .o_det_start(det_start),
    .o_depletion_fet_on(fet_on), .o_key_detect_run(key_run), .o_raw_key_mode(raw_mode), .o_adc_start(adc_start),
    .o_adc_int_set(adc_int), .o_insert_debounced(debounced), .o_key_event_bits(key_bits));
  adks_host u_adks_host (.i_mclk(i_mclk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  task automatic chk(input string n, input logic [7:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      $display("MISMATCH %s exp %h got %h", n, e, s);
      num_errors++;
    end
  endtask
  task automatic wrb(input logic [7:0] a, d);
    u_adks_host.xfer(1'h0, a, d, q);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, e);
    u_adks_host.xfer(1'h1, a, 8'h00, q);
    chk(n, q, e);
  endtask
  task automatic t_det;
    wrb(8'h04, 8'h13);
    rdc("det_no_plug", 8'h04, 8'h03);
    sense = 1'h0;
    wrb(8'h04, 8'h13);
    chk("det_start", {7'h0, det_start}, 8'h01);
    rdc("det_busy", 8'h04, 8'h13);
    det_done = 1'h1;
    @(negedge i_mclk);
    det_done = 1'h0;
    rdc("det_done", 8'h04, 8'h03);
    status = 8'h01;
    wrb(8'h04, 8'h13);
    chk("det_refused", {7'h0, det_start}, 8'h00);
    rdc("det_ignored", 8'h04, 8'h03);
    status = 8'h00;
  endtask
  task automatic t_adc;
    wrb(8'h05, 8'h07);
    chk("adc_start", {7'h0, adc_start}, 8'h01);
    adc_done = 1'h1;
    @(negedge i_mclk);
    adc_done = 1'h0;
    chk("adc_int", {7'h0, adc_int}, 8'h01);
    rdc("adc_trig_clear", 8'h05, 8'h06);
    wrb(8'h05, 8'h03);
    chk("adc_refused", {7'h0, adc_start}, 8'h00);
    rdc("raw_autoclear", 8'h05, 8'h00);
    wrb(8'h05, 8'h06);
    rem = 1'h1;
    @(negedge i_mclk);
    rem = 1'h0;
    rdc("removal", 8'h05, 8'h00);
  endtask
  task automatic t_swreset;
    wrb(8'h04, 8'h4b);
    wrb(8'h04, 8'h80);
    chk("sw_reset", {7'h0, sw_reset}, 8'h01);
    rdc("after_reset", 8'h04, 8'h23);
  endtask
  // auto detection after de-bounce, fm, key run and raw events
  task automatic t_auto;
    int n;
    n = 0;
    while (det_start !== 1'h1 && n < 300)
    begin
      @(negedge i_mclk);
      n++;
    end
    chk("auto_det", {7'h0, det_start}, 8'h01);
    if (n == 300) close_out;
    chk("debounced", {7'h0, debounced}, 8'h01);
    chk("fet_on", {7'h0, fet_on}, 8'h01);
    wrb(8'h04, 8'h28);
    @(negedge i_mclk);
    chk("fet_off", {7'h0, fet_on}, 8'h00);
    wrb(8'h05, 8'h06);
    @(negedge i_mclk);
    chk("key_run", {7'h0, key_run}, 8'h01);
    chk("raw_mode", {7'h0, raw_mode}, 8'h01);
    key_ev = 2'h1;
    @(negedge i_mclk);
    key_ev = 2'h0;
    chk("key_bits", {6'h0, key_bits}, 8'h01);
    key_rd = 1'h1;
    @(negedge i_mclk);
    key_rd = 1'h0;
    chk("key_read_clr", {6'h0, key_bits}, 8'h00);
    matrix = 1'h0;
    wrb(8'h04, 8'h68);
    @(negedge i_mclk);
    chk("key_run_matrix", {7'h0, key_run}, 8'h00);
  endtask
  task automatic close_out;
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // reset for five cycles, released off the sampling edge
  initial
  begin
    repeat (5) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'h0;
    rdc("dev_reset", 8'h04, 8'h23);
    rdc("key_reset", 8'h05, 8'h00);
    rdc("unmapped", 8'h10, 8'h00);
    t_det;
    t_adc;
    t_swreset;
    t_auto;
    close_out;
  end
  // hang guard
  initial
  begin
    #100000;
    num_errors++;
    close_out;
  end
endmodule
`default_nettype wire

// file: core/adks_consts.vh
`ifndef ADKS_CONSTS_VH
`define ADKS_CONSTS_VH
// register offsets
`define ADKS_ADDR_DEV_SET 8'h04
`define ADKS_ADDR_KEY_SET 8'h05
// device settings fields
`define ADKS_DS_SW_RESET 7
`define ADKS_DS_MANUAL_SW 6
`define ADKS_DS_AUTO_DET 5
`define ADKS_DS_DET_REQ 4
`define ADKS_DS_FM 3
`define ADKS_DS_DEB_HI 2
`define ADKS_DS_DEB_LO 0
// key press settings fields
`define ADKS_KS_KEY_EN 2
`define ADKS_KS_RAW 1
`define ADKS_KS_ADC_TRIG 0
// reset values
`define ADKS_DS_RESET 8'h23
`define ADKS_KS_RESET 8'h00
// de-bounce times in ms
`define ADKS_DEB_MS_0 2
`define ADKS_DEB_MS_1 30
`define ADKS_DEB_MS_2 60
`define ADKS_DEB_MS_3 90
`define ADKS_DEB_MS_4 120
`define ADKS_DEB_MS_5 150
`define ADKS_DEB_MS_6 1000
`define ADKS_DEB_MS_7 2000
// clock rate and cycles per ms
`define ADKS_CLK_HZ 100000000
`define ADKS_CYC_PER_MS (`ADKS_CLK_HZ / 1000)
`endif

// file: core/adks_settings.v
`timescale 1ns/100ps
`default_nettype none
`include "adks_consts.vh"
// settings bank behind the serial slave
// the slave decodes the bus and presents one byte per strobe
// reserved bits are not stored and always read back as zero
// a refused manual request leaves no trace in the register
// limitation: the switch control registers themselves live elsewhere
// every control toward the analog side leaves a flip-flop,
// so the analog blocks never see decode glitches
// the cost is one cycle of lag on each level output
// timing counts scale with DEB_SCALE so simulation
// can run the long de-bounce settings in few cycles
module adks_settings #(
  parameter DEB_SCALE = `ADKS_CYC_PER_MS
)
(
  // clock and reset
  input wire i_mclk,
  input wire i_rst,
  // register access from the serial slave
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  // jack and analog side
  input wire i_insertion_sense_pin,
  input wire i_removal,
  input wire [7:0] i_int_status,
  input wire i_det_done,
  input wire i_adc_done,
  input wire i_key_switch_matrix_valid,
  input wire i_key_int_read,
  input wire [1:0] i_key_event,
  // controls to the analog side
  output reg o_sw_reset,
  output reg o_manual_sw,
  output reg o_det_start,
  output reg o_depletion_fet_on,
  output reg o_key_detect_run,
  output reg o_raw_key_mode,
  output reg o_adc_start,
  output reg o_adc_int_set,
  output reg o_insert_debounced,
  output reg [1:0] o_key_event_bits
);
  // stored register images
  reg [7:0] dev_set;
  reg [7:0] key_set;
  // busy covers both manual and automatic detection
  reg busy;
  // the sense pin is sampled once to spot changes
  reg sense_q;
  // counts cycles of stable insertion
  reg [31:0] deb_cnt;
  // field decodes
  wire key_en = key_set[`ADKS_KS_KEY_EN];
  wire raw = key_set[`ADKS_KS_RAW];
  // write strobes per register
  wire wr_ds = i_wr && i_addr == `ADKS_ADDR_DEV_SET;
  wire wr_ks = i_wr && i_addr == `ADKS_ADDR_KEY_SET;
  wire inserted = ~i_insertion_sense_pin;
  // a request is accepted only when nothing blocks it
  wire req_ok = wr_ds && i_wdata[`ADKS_DS_DET_REQ] && !busy && i_int_status == 8'h00 && inserted;
  // disabling key detection, by software or by removal
  wire key_off = i_removal || (wr_ks && !i_wdata[`ADKS_KS_KEY_EN]);
  wire trig_ok = wr_ks && i_wdata[`ADKS_KS_ADC_TRIG] && i_wdata[`ADKS_KS_KEY_EN] && i_wdata[`ADKS_KS_RAW];

  // shared by the de-bounce compare; kept as a table
  // so the odd 1 s and 2 s steps need no arithmetic
  // de-bounce time in ms for a field value
  function [31:0] deb_ms;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: deb_ms = `ADKS_DEB_MS_0;
        3'h1: deb_ms = `ADKS_DEB_MS_1;
        3'h2: deb_ms = `ADKS_DEB_MS_2;
        3'h3: deb_ms = `ADKS_DEB_MS_3;
        3'h4: deb_ms = `ADKS_DEB_MS_4;
        3'h5: deb_ms = `ADKS_DEB_MS_5;
        3'h6: deb_ms = `ADKS_DEB_MS_6;
        default: deb_ms = `ADKS_DEB_MS_7;
      endcase
    end
  endfunction

  // register file and control; soft reset restores both registers next edge, o_manual_sw and o_depletion_fet_on the edge after
  always @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      dev_set <= `ADKS_DS_RESET;
      key_set <= `ADKS_KS_RESET;
      busy <= 1'b0;
      // pin sampler starts at the idle level so no false change
      sense_q <= 1'b1;
      deb_cnt <= 32'h0;
      o_rdata <= 8'h00;
      o_sw_reset <= 1'b0;
      o_manual_sw <= 1'b0;
      o_det_start <= 1'b0;
      o_depletion_fet_on <= 1'b1;
      o_key_detect_run <= 1'b0;
      o_raw_key_mode <= 1'b0;
      o_adc_start <= 1'b0;
      o_adc_int_set <= 1'b0;
      o_insert_debounced <= 1'b0;
      o_key_event_bits <= 2'h0;
    end
    // soft reset outranks every other action in its cycle
    else if (wr_ds && i_wdata[`ADKS_DS_SW_RESET])
    begin
      // pulse out, abort detection and conversion
      dev_set <= `ADKS_DS_RESET;
      key_set <= `ADKS_KS_RESET;
      busy <= 1'b0;
      deb_cnt <= 32'h0;
      o_insert_debounced <= 1'b0;
      o_sw_reset <= 1'b1;
      o_det_start <= 1'b0;
      o_adc_start <= 1'b0;
      o_adc_int_set <= 1'b0;
      o_key_event_bits <= 2'h0;
      o_key_detect_run <= 1'b0;
      o_raw_key_mode <= 1'b0;
      o_rdata <= 8'h00;
    end
    else
    begin
      o_sw_reset <= 1'b0;
      o_det_start <= 1'b0;
      o_adc_start <= 1'b0;
      // the interrupt only follows a conversion this bank asked for
      o_adc_int_set <= i_adc_done && key_set[`ADKS_KS_ADC_TRIG];
      // previous sense level for change detection
      sense_q <= i_insertion_sense_pin;
      // insertion de-bounce; restarts on every change of the sense pin
      if (!inserted || i_insertion_sense_pin != sense_q)
      begin
        deb_cnt <= 32'h0;
        o_insert_debounced <= 1'b0;
      end
      else if (!o_insert_debounced)
      begin
        // compare against one less so the count ends on time
        if (deb_cnt >= deb_ms(dev_set[`ADKS_DS_DEB_HI:`ADKS_DS_DEB_LO]) * DEB_SCALE - 1)
        begin
          o_insert_debounced <= 1'b1;
          // auto detection only when enabled
          if (dev_set[`ADKS_DS_AUTO_DET] && !busy)
          begin
            busy <= 1'b1;
            o_det_start <= 1'b1;
          end
        end
        else
          deb_cnt <= deb_cnt + 32'h1;
      end
      // device settings write; request bit stored only when accepted
      if (wr_ds)
        dev_set <= {1'b0, i_wdata[6:5], req_ok | dev_set[`ADKS_DS_DET_REQ], i_wdata[3:0]};
      if (req_ok)
      begin
        busy <= 1'b1;
        o_det_start <= 1'b1;
      end
      // done without busy is a stray pulse and is ignored
      // completion clears the request bit; wins over a concurrent write
      if (i_det_done && busy)
      begin
        busy <= 1'b0;
        dev_set[`ADKS_DS_DET_REQ] <= 1'b0;
      end
      // removal outranks a same-cycle write so a stale enable cannot stick
      // key press settings
      if (key_off)
        key_set <= 8'h00;
      else if (wr_ks)
      begin
        key_set[`ADKS_KS_KEY_EN] <= i_wdata[`ADKS_KS_KEY_EN];
        key_set[`ADKS_KS_RAW] <= i_wdata[`ADKS_KS_RAW];
        // new trigger accepted regardless of unserviced interrupt
        key_set[`ADKS_KS_ADC_TRIG] <= trig_ok | (key_set[`ADKS_KS_ADC_TRIG] & ~i_adc_done);
        if (trig_ok)
          o_adc_start <= 1'b1;
      end
      else if (i_adc_done)
        key_set[`ADKS_KS_ADC_TRIG] <= 1'b0;
      // raw key events; cleared on disable or read, new event wins over read
      if (key_off)
        o_key_event_bits <= 2'h0;
      else if (raw)
        o_key_event_bits <= (i_key_int_read ? 2'h0 : o_key_event_bits) | i_key_event;
      else if (i_key_int_read)
        o_key_event_bits <= 2'h0;
      // a soft reset skips o_manual_sw and o_depletion_fet_on, so they settle the edge after; it clears key run and raw itself
      // switch and key run controls
      o_manual_sw <= dev_set[`ADKS_DS_MANUAL_SW];
      o_depletion_fet_on <= !(dev_set[`ADKS_DS_FM] && o_insert_debounced);
      o_key_detect_run <= key_en && !key_off && (!dev_set[`ADKS_DS_MANUAL_SW] || i_key_switch_matrix_valid);
      o_raw_key_mode <= raw && !key_off;
      // reads have no side effect on these two registers
      // registered read data
      if (i_rd)
        o_rdata <= (i_addr == `ADKS_ADDR_DEV_SET) ? dev_set : (i_addr == `ADKS_ADDR_KEY_SET) ? key_set : 8'h00;
    end
  end
endmodule
`default_nettype wire
